// ===== src/fpei_top.sv
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module fpei_top #(
    parameter int PAGES = 4,
    parameter int PAGE_WORDS = 64,
    parameter int BOOT_WORDS = 32
) (
    input wire logic I_CLK,                          // 100 MHz bus clock
    input wire logic I_RSTN,                         // synchronous reset, active low
    input wire logic [fpei_pkg::ADDR_W-1:0] I_AWADDR, // write address
    input wire logic I_AWVALID,                      // write address valid
    output logic O_AWREADY,                          // write address ready
    input wire logic [31:0] I_WDATA,                 // write data
    input wire logic [3:0] I_WSTRB,                  // write byte strobes
    input wire logic I_WVALID,                       // write data valid
    output logic O_WREADY,                           // write data ready
    output logic [1:0] O_BRESP,                      // write response
    output logic O_BVALID,                           // write response valid
    input wire logic I_BREADY,                       // write response ready
    input wire logic [fpei_pkg::ADDR_W-1:0] I_ARADDR, // read address
    input wire logic I_ARVALID,                      // read address valid
    output logic O_ARREADY,                          // read address ready
    output logic [31:0] O_RDATA,                     // read data
    output logic [1:0] O_RRESP,                      // read response
    output logic O_RVALID,                           // read data valid
    input wire logic I_RREADY,                       // read data ready
    output logic O_HV_APPLY,                         // program/erase voltage gate
    output logic [$clog2(PAGES)-1:0] O_PAGE_SELECT   // current program page
);
    localparam int DEPTH = PAGES * PAGE_WORDS;
    localparam int IDX_W = $clog2(DEPTH);
    localparam int PAGE_W = $clog2(PAGES);
    localparam int OFS_W = $clog2(PAGE_WORDS);

    // ******************************************
    // parameter checks
    // ******************************************
    if (PAGES < 2 || (1 << PAGE_W) != PAGES || PAGE_WORDS < 2 || (1 << OFS_W) != PAGE_WORDS
        || PAGE_WORDS > 1024 || BOOT_WORDS < 1 || BOOT_WORDS > DEPTH || IDX_W > 16) begin : g_bad_params
        $error("fpei_top: pages and page words must be powers of two, window within 4 KiB");
    end

    // ******************************************
    // declarations
    // ******************************************
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [fpei_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic arready_q;
    logic rd_wait_q;
    logic rd_go_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [fpei_pkg::ADDR_W-1:0] ar_addr_q;
    logic [IDX_W-1:0] rd_idx_q;
    logic hv_q;
    logic latch_q;
    logic erase_q;
    logic bprot_q;
    logic loaded_q;
    logic op_go_q;
    logic [PAGE_W-1:0] page_q;
    logic [IDX_W-1:0] latch_idx_q;
    logic [fpei_pkg::DATA_W-1:0] latch_data_q;
    logic [1:0] latch_lanes_q;
    logic wr_fire;
    logic wr_ctrl;
    logic hv_ok;
    fpei_pkg::fpei_region_t wr_region;
    fpei_pkg::fpei_region_t rd_region;
    logic [IDX_W-1:0] wr_idx;
    logic [1:0] wr_lanes;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    fpei_array_if #(.IDX_W(IDX_W)) arr ();

    function automatic fpei_pkg::fpei_region_t decode(input logic [fpei_pkg::ADDR_W-1:0] a);
        logic [fpei_pkg::ADDR_W-1:0] w;
        logic [16:0] top;
        w = {a[fpei_pkg::ADDR_W-1:2], 2'h0};
        top = {1'b0, fpei_pkg::ARRAY_BASE} + 17'(4 * PAGE_WORDS);
        if (w == fpei_pkg::CTRL_OFS) return fpei_pkg::REGION_CTRL;
        if (w == fpei_pkg::CONFIG_OFS) return fpei_pkg::REGION_CONFIG;
        if (w == fpei_pkg::PAGE_OFS) return fpei_pkg::REGION_PAGE;
        if (w == fpei_pkg::STATUS_OFS) return fpei_pkg::REGION_STATUS;
        if (w >= fpei_pkg::ARRAY_BASE && {1'b0, w} < top) return fpei_pkg::REGION_ARRAY;
        return fpei_pkg::REGION_NONE;
    endfunction

    // ******************************************
    // write channels
    // ******************************************
    // one write at a time: both halves are held until the response is taken
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            awready_q <= 1'b1;
            aw_addr_q <= '0;
        end else if (awready_q && I_AWVALID) begin
            awready_q <= 1'b0;
            aw_addr_q <= I_AWADDR;
        end else if (bvalid_q && I_BREADY) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            wready_q <= 1'b1;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wready_q && I_WVALID) begin
            wready_q <= 1'b0;
            w_data_q <= I_WDATA;
            w_strb_q <= I_WSTRB;
        end else if (bvalid_q && I_BREADY) begin
            wready_q <= 1'b1;
        end
    end

    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign wr_region = decode(aw_addr_q);
    assign wr_ctrl = wr_fire && (wr_region == fpei_pkg::REGION_CTRL) && w_strb_q[0];
    // byte lane 0 alone is the even byte, lane 1 alone the odd byte, both the aligned word
    assign wr_lanes = w_strb_q[1:0];
    assign wr_idx = {page_q, aw_addr_q[OFS_W+1:2]};

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            bvalid_q <= 1'b0;
            bresp_q <= fpei_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_region == fpei_pkg::REGION_NONE) ? fpei_pkg::RESP_SLVERR : fpei_pkg::RESP_OKAY;
        end else if (bvalid_q && I_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ******************************************
    // control bits
    // ******************************************
    // voltage may only come on with latches loaded and latch_enable kept set in the same write
    assign hv_ok = w_data_q[fpei_pkg::CTRL_HV_BIT] && w_data_q[fpei_pkg::CTRL_LATCH_BIT]
                   && latch_q && loaded_q;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            hv_q <= fpei_pkg::CTRL_RST;
            latch_q <= fpei_pkg::CTRL_RST;
            erase_q <= fpei_pkg::CTRL_RST;
            op_go_q <= 1'b0;
        end else begin
            op_go_q <= wr_ctrl && !hv_q && hv_ok;
            if (wr_ctrl) begin
                if (hv_q) begin
                    // latch_enable and erase_select hold; only hv_apply may drop
                    hv_q <= w_data_q[fpei_pkg::CTRL_HV_BIT];
                end else begin
                    hv_q <= hv_ok;
                    latch_q <= w_data_q[fpei_pkg::CTRL_LATCH_BIT];
                    erase_q <= w_data_q[fpei_pkg::CTRL_ERASE_BIT];
                end
            end
        end
    end

    // ******************************************
    // programming latches
    // ******************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            loaded_q <= 1'b0;
            latch_idx_q <= '0;
            latch_data_q <= '0;
            latch_lanes_q <= '0;
        end else if (!latch_q) begin
            loaded_q <= 1'b0;
        end else if (wr_fire && wr_region == fpei_pkg::REGION_ARRAY && !loaded_q && !hv_q
                     && wr_lanes != 2'h0) begin
            // erase takes any address; program skips the boot block while protected
            if (erase_q || !(bprot_q && fpei_pkg::fpei_in_boot(32'(wr_idx), DEPTH, BOOT_WORDS))) begin
                loaded_q <= 1'b1;
                latch_idx_q <= wr_idx;
                latch_data_q <= w_data_q[fpei_pkg::DATA_W-1:0];
                latch_lanes_q <= wr_lanes;
            end
        end
    end

    // ******************************************
    // configuration and page
    // ******************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            bprot_q <= fpei_pkg::BPROT_RST;
        end else if (wr_fire && wr_region == fpei_pkg::REGION_CONFIG && w_strb_q[0] && !hv_q) begin
            bprot_q <= w_data_q[fpei_pkg::CONFIG_BPROT_BIT];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            page_q <= '0;
        end else if (wr_fire && wr_region == fpei_pkg::REGION_PAGE && w_strb_q[0]) begin
            page_q <= w_data_q[PAGE_W-1:0];
        end
    end

    // ******************************************
    // array operations
    // ******************************************
    // one operation per hv_apply rising; software repeats pulses itself
    assign arr.op_go = op_go_q;
    assign arr.op_erase = erase_q;
    assign arr.boot_protect = bprot_q;
    assign arr.op_idx = latch_idx_q;
    assign arr.op_data = latch_data_q;
    assign arr.op_lanes = latch_lanes_q;
    assign arr.rd_idx = rd_idx_q;

    fpei_array #(.DEPTH(DEPTH), .BOOT_WORDS(BOOT_WORDS)) u_array (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .arr(arr.store)
    );

    // ******************************************
    // read channel
    // ******************************************
    // three cycles from address to data: one to select, one for the array read, one to register the response
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            arready_q <= 1'b1;
            ar_addr_q <= '0;
            rd_idx_q <= '0;
            rd_wait_q <= 1'b0;
            rd_go_q <= 1'b0;
        end else begin
            rd_wait_q <= 1'b0;
            rd_go_q <= rd_wait_q;
            if (arready_q && I_ARVALID) begin
                arready_q <= 1'b0;
                ar_addr_q <= I_ARADDR;
                rd_wait_q <= 1'b1;
                if (latch_q && !erase_q && !hv_q && loaded_q) begin
                    rd_idx_q <= latch_idx_q;
                end else begin
                    rd_idx_q <= {page_q, I_ARADDR[OFS_W+1:2]};
                end
            end else if (rvalid_q && I_RREADY) begin
                arready_q <= 1'b1;
            end
        end
    end

    assign rd_region = decode(ar_addr_q);

    always_comb begin
        rd_word = '0;
        rd_resp = fpei_pkg::RESP_OKAY;
        case (rd_region)
            fpei_pkg::REGION_CTRL: begin
                rd_word[fpei_pkg::CTRL_HV_BIT] = hv_q;
                rd_word[fpei_pkg::CTRL_LATCH_BIT] = latch_q;
                rd_word[fpei_pkg::CTRL_ERASE_BIT] = erase_q;
            end
            fpei_pkg::REGION_CONFIG: begin
                rd_word[fpei_pkg::CONFIG_BPROT_BIT] = bprot_q;
            end
            fpei_pkg::REGION_PAGE: begin
                rd_word[PAGE_W-1:0] = page_q;
            end
            fpei_pkg::REGION_STATUS: begin
                rd_word[fpei_pkg::STATUS_LOADED_BIT] = loaded_q;
                rd_word[fpei_pkg::STATUS_IDX_LSB +: IDX_W] = latch_idx_q;
            end
            fpei_pkg::REGION_ARRAY: begin
                // a read under high voltage gets no array data
                if (hv_q) begin
                    rd_resp = fpei_pkg::RESP_SLVERR;
                end else begin
                    rd_word[fpei_pkg::DATA_W-1:0] = arr.rd_data;
                end
            end
            default: begin
                rd_resp = fpei_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            rvalid_q <= 1'b0;
            rresp_q <= fpei_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_go_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_resp;
            rdata_q <= rd_word;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ******************************************
    // outputs
    // ******************************************
    assign O_AWREADY = awready_q;
    assign O_WREADY = wready_q;
    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;
    assign O_ARREADY = arready_q;
    assign O_RVALID = rvalid_q;
    assign O_RRESP = rresp_q;
    assign O_RDATA = rdata_q;
    assign O_HV_APPLY = hv_q;
    assign O_PAGE_SELECT = page_q;
endmodule // fpei_top

// ===== inc/fpei_pkg.sv
package fpei_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    // ******************************************
    // register map
    // ******************************************
    localparam logic [15:0] CTRL_OFS = 16'h0000;
    localparam logic [15:0] CONFIG_OFS = 16'h0004;
    localparam logic [15:0] PAGE_OFS = 16'h0008;
    localparam logic [15:0] STATUS_OFS = 16'h000c;
    localparam logic [15:0] ARRAY_BASE = 16'h1000;
    // ******************************************
    // fields and reset values
    // ******************************************
    localparam int CTRL_HV_BIT = 0;
    localparam int CTRL_LATCH_BIT = 1;
    localparam int CTRL_ERASE_BIT = 2;
    localparam int CONFIG_BPROT_BIT = 0;
    localparam int STATUS_LOADED_BIT = 0;
    localparam int STATUS_IDX_LSB = 16;
    localparam logic CTRL_RST = 1'b0;
    localparam logic BPROT_RST = 1'b1;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {REGION_CTRL, REGION_CONFIG, REGION_PAGE, REGION_STATUS, REGION_ARRAY, REGION_NONE} fpei_region_t;

    // the boot block is the top boot_words words of the array
    function automatic logic fpei_in_boot(input int unsigned idx, input int unsigned depth,
                                          input int unsigned boot_words);
        return idx >= (depth - boot_words);
    endfunction
endpackage

// ===== inc/fpei_array_if.sv
`timescale 1ns/1ps
interface fpei_array_if #(parameter int IDX_W = 8) ();
    logic op_go;
    logic op_erase;
    logic boot_protect;
    logic [IDX_W-1:0] op_idx;
    logic [fpei_pkg::DATA_W-1:0] op_data;
    logic [1:0] op_lanes;
    logic [IDX_W-1:0] rd_idx;
    logic [fpei_pkg::DATA_W-1:0] rd_data;

    modport ctrl (output op_go, output op_erase, output boot_protect, output op_idx, output op_data,
                  output op_lanes, output rd_idx, input rd_data);
    modport store (input op_go, input op_erase, input boot_protect, input op_idx, input op_data,
                   input op_lanes, input rd_idx, output rd_data);
endinterface

// ===== src/fpei_array.sv
`timescale 1ns/1ps
module fpei_array #(
    parameter int DEPTH = 256,
    parameter int BOOT_WORDS = 32
) (
    input wire logic i_clk,      // bus clock
    input wire logic i_rstn,     // synchronous reset, active low
    fpei_array_if.store arr      // operations from the sequencer
);
    logic [fpei_pkg::DATA_W-1:0] mem [DEPTH];
    logic [fpei_pkg::DATA_W-1:0] rd_q;
    logic [fpei_pkg::DATA_W-1:0] lane_mask;

    assign lane_mask = {{8{arr.op_lanes[1]}}, {8{arr.op_lanes[0]}}};
    assign arr.rd_data = rd_q;

    // ******************************************
    // cell array
    // ******************************************
    // contents come up erased so a simulation starts from a known array
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= fpei_pkg::ERASED_WORD;
            end
        end else if (arr.op_go) begin
            if (arr.op_erase) begin
                for (int i = 0; i < DEPTH; i++) begin
                    if (!(arr.boot_protect && fpei_pkg::fpei_in_boot(i, DEPTH, BOOT_WORDS))) begin
                        mem[i] <= fpei_pkg::ERASED_WORD;
                    end
                end
            end else begin
                // unselected lanes keep their bits; selected lanes can only lose ones
                mem[arr.op_idx] <= mem[arr.op_idx] & (arr.op_data | ~lane_mask);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem[arr.rd_idx];
        end
    end
endmodule // fpei_array

// ===== verification/fpei_monitor.sv
`timescale 1ns/1ps
module fpei_monitor #(
    parameter int PAGES = 4,
    parameter int PAGE_WORDS = 64
) (
    input wire logic I_CLK,                           // bus clock
    input wire logic I_RSTN,                          // sync reset, active low
    input wire logic [fpei_pkg::ADDR_W-1:0] I_AWADDR, // write address
    input wire logic I_AWVALID,                       // write address valid
    input wire logic O_AWREADY,                       // write address ready
    input wire logic [31:0] I_WDATA,                  // write data
    input wire logic [3:0] I_WSTRB,                   // write strobes
    input wire logic I_WVALID,                        // write data valid
    input wire logic O_WREADY,                        // write data ready
    input wire logic [1:0] O_BRESP,                   // write response
    input wire logic O_BVALID,                        // write response valid
    input wire logic I_BREADY,                        // write response ready
    input wire logic [fpei_pkg::ADDR_W-1:0] I_ARADDR, // read address
    input wire logic I_ARVALID,                       // read address valid
    input wire logic O_ARREADY,                       // read address ready
    input wire logic [31:0] O_RDATA,                  // read data
    input wire logic [1:0] O_RRESP,                   // read response
    input wire logic O_RVALID,                        // read data valid
    input wire logic I_RREADY,                        // read data ready
    input wire logic O_HV_APPLY,                      // voltage gate
    input wire logic [$clog2(PAGES)-1:0] O_PAGE_SELECT // page select
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);
    // ******************************************
    // control outputs
    // ******************************************
    // voltage may only switch as the result of a completed control write
    property p_hv_cause;
        !$stable(O_HV_APPLY) |-> $rose(O_BVALID);
    endproperty
    a_hv_cause: assert property (p_hv_cause) else $error("hv apply changed without a write");
    property p_page_cause;
        !$stable(O_PAGE_SELECT) |-> $rose(O_BVALID);
    endproperty
    a_page_cause: assert property (p_page_cause) else $error("page select changed without a write");
    property p_reset_vals;
        disable iff (1'b0) !I_RSTN |=> !O_HV_APPLY && O_PAGE_SELECT == '0 && !O_BVALID && !O_RVALID;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
    property p_hv_read;
        I_ARVALID && O_ARREADY && O_HV_APPLY && I_ARADDR >= fpei_pkg::ARRAY_BASE
            && {1'b0, I_ARADDR} < {1'b0, fpei_pkg::ARRAY_BASE} + 17'(4 * PAGE_WORDS)
            |-> ##[1:4] (O_RVALID && O_RRESP == 2'h2 && O_RDATA == 32'h0);
    endproperty
    a_hv_read: assert property (p_hv_read) else $error("array read under voltage not refused");
    // ******************************************
    // bus handshakes
    // ******************************************
    property p_wr_answer;
        I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:3] O_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_rd_answer;
        I_ARVALID && O_ARREADY |-> ##[1:4] O_RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read response late");
    property p_b_hold;
        O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_busy;
        O_BVALID |-> !O_AWREADY && !O_WREADY;
    endproperty
    a_busy: assert property (p_busy) else $error("write taken while response pending");
endmodule // fpei_monitor

bind fpei_top fpei_monitor #(.PAGES(PAGES), .PAGE_WORDS(PAGE_WORDS)) u_mon (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .O_HV_APPLY(O_HV_APPLY), .O_PAGE_SELECT(O_PAGE_SELECT)
);

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, hv;
    logic [1:0] b_resp, r_resp, page;
    logic [31:0] r_data, rd_d;
    logic [1:0] rd_r;
    int err_count = 0, num_checks = 0, cyc = 0;

    fpei_top uut (
        .I_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(aw_rdy),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(w_rdy), .O_BRESP(b_resp),
        .O_BVALID(b_vld), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(ar_rdy),
        .O_RDATA(r_data), .O_RRESP(r_resp), .O_RVALID(r_vld), .I_RREADY(rready), .O_HV_APPLY(hv),
        .O_PAGE_SELECT(page)
    );

    always #5 clk = ~clk;

    // ******************************************
    // checking and closing
    // ******************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hang anywhere in the bus tasks ends up here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ******************************************
    // bus master
    // ******************************************
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er = 2'h0);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && aw_rdy) awvalid <= 1'b0;
            if (wvalid && w_rdy) wvalid <= 1'b0;
            if (b_vld) begin
                done = 1'b1;
                bready <= 1'b0;
                chk("bresp", {30'h0, b_resp}, {30'h0, er});
            end
        end
    endtask

    task automatic rd(input logic [15:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && ar_rdy) arvalid <= 1'b0;
            if (r_vld) begin
                done = 1'b1;
                rd_d = r_data;
                rd_r = r_resp;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e,
                        input logic [1:0] er = 2'h0);
        rd(a);
        chk(nm, rd_d, e);
        chk("rresp", {30'h0, rd_r}, {30'h0, er});
    endtask

    // one complete pass: latch, one voltage pulse, release
    task automatic op(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s, input logic er);
        wr(16'h0000, {29'h0, er, 2'b10}, 4'hf);
        wr(a, {16'h0, d}, s);
        wr(16'h0000, {29'h0, er, 2'b11}, 4'hf);
        wr(16'h0000, {29'h0, er, 2'b10}, 4'hf);
        wr(16'h0000, 32'h0, 4'hf);
    endtask

    // ******************************************
    // scenarios
    // ******************************************
    task automatic t_reset();
        rchk("ctrl", 16'h0000, 32'h0);
        rchk("config", 16'h0004, 32'h1);
        rchk("page", 16'h0008, 32'h0);
        rchk("erased", 16'h1000, 32'hffff);
        wr(16'h0100, 32'h1, 4'hf, 2'h2);
        rd(16'h0100);
        chk("unmapped", {30'h0, rd_r}, 32'h2);
        $display("test reset done");
    endtask

    task automatic t_no_latch();
        wr(16'h0000, 32'h1, 4'hf);
        chk("hv", {31'h0, hv}, 32'h0);
        rchk("ctrl", 16'h0000, 32'h0);
        wr(16'h0000, 32'h2, 4'hf);
        wr(16'h0000, 32'h3, 4'hf);
        chk("hv", {31'h0, hv}, 32'h0);
        rchk("ctrl", 16'h0000, 32'h2);
        wr(16'h0000, 32'h0, 4'hf);
        $display("test no_latch done");
    endtask

    task automatic t_program();
        op(16'h1008, 16'h0ff0, 4'h3, 1'b0);
        wr(16'h0000, 32'h2, 4'hf);
        wr(16'h1000, 32'h12f0, 4'h3);
        rchk("status", 16'h000c, 32'h1);
        wr(16'h1004, 32'h0, 4'h3);
        rchk("latched", 16'h1008, 32'hffff);
        wr(16'h0000, 32'h3, 4'hf);
        chk("hv", {31'h0, hv}, 32'h1);
        rchk("hv_read", 16'h1008, 32'h0, 2'h2);
        wr(16'h0000, 32'h5, 4'hf);
        rchk("ctrl", 16'h0000, 32'h3);
        wr(16'h0004, 32'h0, 4'hf);
        wr(16'h0000, 32'h2, 4'hf);
        chk("hv", {31'h0, hv}, 32'h0);
        wr(16'h0000, 32'h0, 4'hf);
        rd(16'h000c);
        chk("loaded", rd_d & 32'h1, 32'h0);
        rchk("config", 16'h0004, 32'h1);
        rchk("word0", 16'h1000, 32'h12f0);
        rchk("word1", 16'h1004, 32'hffff);
        rchk("word2", 16'h1008, 32'h0ff0);
        op(16'h1000, 16'hff0f, 4'h1, 1'b0);
        rchk("low_byte", 16'h1000, 32'h1200);
        op(16'h1000, 16'h02ff, 4'h2, 1'b0);
        rchk("high_byte", 16'h1000, 32'h0200);
        op(16'h1000, 16'hffff, 4'h3, 1'b0);
        rchk("no_set", 16'h1000, 32'h0200);
        $display("test program done");
    endtask

    task automatic t_boot();
        wr(16'h0008, 32'h3, 4'hf);
        chk("page_port", {30'h0, page}, 32'h3);
        wr(16'h0000, 32'h2, 4'hf);
        wr(16'h10a0, 32'h0, 4'h3);
        rd(16'h000c);
        chk("boot_latch", rd_d & 32'h1, 32'h0);
        wr(16'h0000, 32'h3, 4'hf);
        chk("hv", {31'h0, hv}, 32'h0);
        wr(16'h0000, 32'h0, 4'hf);
        rchk("boot_word", 16'h10a0, 32'hffff);
        wr(16'h0004, 32'h0, 4'hf);
        op(16'h10a0, 16'h1234, 4'h3, 1'b0);
        op(16'h1000, 16'h5555, 4'h3, 1'b0);
        wr(16'h0004, 32'h1, 4'hf);
        op(16'h1004, 16'h0, 4'h3, 1'b1);
        rchk("boot_kept", 16'h10a0, 32'h1234);
        rchk("p3_erased", 16'h1000, 32'hffff);
        wr(16'h0008, 32'h0, 4'hf);
        rchk("p0_erased", 16'h1000, 32'hffff);
        wr(16'h0004, 32'h0, 4'hf);
        op(16'h1000, 16'h0, 4'h3, 1'b1);
        wr(16'h0008, 32'h3, 4'hf);
        rchk("boot_erased", 16'h10a0, 32'hffff);
        $display("test boot done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        chk("hv_reset", {31'h0, hv}, 32'h0);
        t_reset();
        t_no_latch();
        t_program();
        t_boot();
        give_verdict();
    end
endmodule // tb
